/* hw/fhc_pkg.sv */
// Summary of operation
// - Main erase is six writes, last 30 at 555; erase starts after rise.
// - Word program is AA@555, 55@AAA, A0@555, then data at target address.
// - Boot lockout is a six-cycle sequence ending 40 written to 555.
// - Next access starts only after end of program is detected or the poll limit is reached.
package fhc_pkg;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_NS = 10;
    localparam int T_ACC_NS = 45;
    localparam int T_WE_LOW_NS = 35;
    localparam int T_GLITCH_NS = 15;
    localparam int T_REC_NS = 20;
    localparam logic [7:0] ACC_CYC = 8'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] WE_CYC = 8'((T_WE_LOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] REC_CYC = 8'((T_REC_NS + CLK_NS - 1) / CLK_NS);

    // ----------------------------------------------------------------
    // Command codes
    // ----------------------------------------------------------------
    localparam logic [15:0] ADDR_UNLOCK1 = 16'h0555;
    localparam logic [15:0] ADDR_UNLOCK2 = 16'h0AAA;
    localparam logic [15:0] ADDR_ANY = 16'h0000;
    localparam logic [15:0] DAT_UNLOCK1 = 16'h00AA;
    localparam logic [15:0] DAT_UNLOCK2 = 16'h0055;
    localparam logic [15:0] DAT_SETUP = 16'h0080;
    localparam logic [15:0] DAT_CHIP_ERASE = 16'h0010;
    localparam logic [15:0] DAT_MAIN_ERASE = 16'h0030;
    localparam logic [15:0] DAT_PROGRAM = 16'h00A0;
    localparam logic [15:0] DAT_LOCKOUT = 16'h0040;
    localparam logic [15:0] DAT_ID_ENTRY = 16'h0090;
    localparam logic [15:0] DAT_ID_EXIT = 16'h00F0;
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    localparam logic [15:0] ID_LOCK_ADDR = 16'h0002;

    typedef enum logic [2:0] {
        FHC_READ = 3'h0,
        FHC_PROGRAM = 3'h1,
        FHC_CHIP_ERASE = 3'h2,
        FHC_MAIN_ERASE = 3'h3,
        FHC_LOCKOUT = 3'h4,
        FHC_ID_ENTRY = 3'h5,
        FHC_ID_EXIT = 3'h6,
        FHC_ID_EXIT_SHORT = 3'h7
    } fhc_cmd_e;

    typedef struct packed {
        fhc_cmd_e cmd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } fhc_req_s;

    typedef struct packed {
        logic [15:0] rdata;
        logic timeout;
    } fhc_rsp_s;

    typedef struct packed {
        logic chip_sel_n;
        logic out_drive_n;
        logic wr_strobe_n;
        logic [15:0] address_lines;
        logic [15:0] data_lines_out;
        logic data_lines_oe;
    } fhc_pins_s;
endpackage

/* hw/fhc_bus_cycle.sv */
`timescale 1ns/1ps
module fhc_bus_cycle (
    input wire logic mclk,                      // System clock
    input wire logic rst_n,                     // Synchronous reset
    input wire logic start,                     // Begin one bus cycle
    input wire logic is_write,                  // Write cycle when high
    input wire logic [15:0] addr,               // Cycle address
    input wire logic [15:0] wdata,              // Write data
    output logic done,                          // One-cycle end pulse
    output logic [15:0] rdata,                  // Captured read data
    output fhc_pkg::fhc_pins_s pins,            // Flash pin drive
    input wire logic [15:0] data_lines_in       // Flash data lines
);
    typedef enum logic [3:0] {
        B_IDLE = 4'b0001,
        B_SETUP = 4'b0010,
        B_STROBE = 4'b0100,
        B_HOLD = 4'b1000
    } fhc_bstate_e;

    fhc_bstate_e state, next_state;
    logic [7:0] cnt, next_cnt;
    logic wr, next_wr;
    logic [15:0] next_rdata;
    fhc_pkg::fhc_pins_s next_pins;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_wr = wr;
        next_rdata = rdata;
        next_pins = pins;
        done = 1'b0;
        case (state)
            B_IDLE: begin
                if (start) begin
                    // Address and chip select settle before any strobe falls
                    next_wr = is_write;
                    next_pins.address_lines = addr;
                    next_pins.data_lines_out = wdata;
                    next_pins.data_lines_oe = is_write;
                    next_pins.chip_sel_n = 1'b0;
                    next_state = B_SETUP;
                end
            end
            B_SETUP: begin
                // Strobe falls after chip select: device takes address here
                if (wr) begin
                    next_pins.wr_strobe_n = 1'b0;
                    next_cnt = fhc_pkg::WE_CYC;
                end else begin
                    next_pins.out_drive_n = 1'b0;
                    next_cnt = fhc_pkg::ACC_CYC;
                end
                next_state = B_STROBE;
            end
            B_STROBE: begin
                // Strobe low well past the glitch filter width
                if (cnt == 8'h01) begin
                    next_pins.wr_strobe_n = 1'b1;
                    next_pins.out_drive_n = 1'b1;
                    if (!wr) begin
                        next_rdata = data_lines_in;
                    end
                    next_cnt = fhc_pkg::REC_CYC;
                    next_state = B_HOLD;
                end else begin
                    next_cnt = cnt - 8'h01;
                end
            end
            B_HOLD: begin
                // Strobe rose first, data held one more cycle, then release
                next_pins.data_lines_oe = 1'b0;
                next_pins.chip_sel_n = 1'b1;
                if (cnt == 8'h01) begin
                    done = 1'b1;
                    next_state = B_IDLE;
                end else begin
                    next_cnt = cnt - 8'h01;
                end
            end
            default: next_state = B_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state <= B_IDLE;
            cnt <= 8'h00;
            wr <= 1'b0;
            rdata <= 16'h0000;
            pins <= '{1'b1, 1'b1, 1'b1, 16'h0000, 16'h0000, 1'b0};
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            wr <= next_wr;
            rdata <= next_rdata;
            pins <= next_pins;
        end
    end
endmodule

/* hw/fhc_ctrl.sv */
`timescale 1ns/1ps
module fhc_ctrl #(
    parameter logic [31:0] POLL_LIMIT = 32'h00FFFFFF // Poll reads before timeout
) (
    input wire logic mclk,                      // System clock, 100 MHz
    input wire logic rst_n,                     // Synchronous reset, active low
    input wire logic req_valid,                 // User request offered
    output logic req_ready,                     // Request taken this cycle
    input wire fhc_pkg::fhc_req_s req,          // Command, address, data
    output logic rsp_valid,                     // One-cycle completion pulse
    output fhc_pkg::fhc_rsp_s rsp,              // Read data and timeout flag
    output fhc_pkg::fhc_pins_s pins,            // Flash control, address, data out
    input wire logic [15:0] data_lines_in       // Flash data lines as seen
);
    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_ISSUE = 5'b00010,
        S_WAIT = 5'b00100,
        S_POLL = 5'b01000,
        S_POLL_WAIT = 5'b10000
    } fhc_state_e;

    fhc_state_e state, next_state;
    fhc_pkg::fhc_req_s cur, next_cur;
    logic [2:0] step, next_step;
    logic [31:0] polls, next_polls;
    logic have_prev, next_have_prev;
    logic prev_toggle, next_prev_toggle;
    logic [15:0] next_rdata;
    logic next_timeout;
    logic next_rsp_valid;
    logic bus_start;
    logic bus_write;
    logic [15:0] bus_addr;
    logic [15:0] bus_wdata;
    logic bus_done;
    logic [15:0] bus_rdata;
    logic [2:0] seq_len;
    logic [15:0] step_addr;
    logic [15:0] step_data;
    logic is_erase;

    // Number of bus cycles in each command sequence
    always_comb begin
        case (cur.cmd)
            fhc_pkg::FHC_READ: seq_len = 3'h1;
            fhc_pkg::FHC_PROGRAM: seq_len = 3'h4;
            fhc_pkg::FHC_ID_ENTRY: seq_len = 3'h3;
            fhc_pkg::FHC_ID_EXIT: seq_len = 3'h3;
            fhc_pkg::FHC_ID_EXIT_SHORT: seq_len = 3'h1;
            default: seq_len = 3'h6;
        endcase
    end

    // Address and data of the current step; only low address and data bits
    // carry meaning to the device, the upper ones are driven as zero in command cycles
    always_comb begin
        step_addr = fhc_pkg::ADDR_UNLOCK1;
        step_data = fhc_pkg::DAT_UNLOCK1;
        case (step)
            3'h0: begin
                if (cur.cmd == fhc_pkg::FHC_ID_EXIT_SHORT) begin
                    step_addr = fhc_pkg::ADDR_ANY;
                    step_data = fhc_pkg::DAT_ID_EXIT;
                end else if (cur.cmd == fhc_pkg::FHC_READ) begin
                    step_addr = cur.addr;
                end
            end
            3'h1, 3'h4: begin
                step_addr = fhc_pkg::ADDR_UNLOCK2;
                step_data = fhc_pkg::DAT_UNLOCK2;
            end
            3'h2: begin
                case (cur.cmd)
                    fhc_pkg::FHC_PROGRAM: step_data = fhc_pkg::DAT_PROGRAM;
                    fhc_pkg::FHC_ID_ENTRY: step_data = fhc_pkg::DAT_ID_ENTRY;
                    fhc_pkg::FHC_ID_EXIT: step_data = fhc_pkg::DAT_ID_EXIT;
                    default: step_data = fhc_pkg::DAT_SETUP;
                endcase
            end
            3'h3: begin
                if (cur.cmd == fhc_pkg::FHC_PROGRAM) begin
                    step_addr = cur.addr;
                    step_data = cur.wdata;
                end
            end
            3'h5: begin
                case (cur.cmd)
                    fhc_pkg::FHC_CHIP_ERASE: step_data = fhc_pkg::DAT_CHIP_ERASE;
                    fhc_pkg::FHC_MAIN_ERASE: step_data = fhc_pkg::DAT_MAIN_ERASE;
                    default: step_data = fhc_pkg::DAT_LOCKOUT;
                endcase
            end
            default: step_data = fhc_pkg::DAT_UNLOCK1;
        endcase
    end

    assign is_erase = (cur.cmd == fhc_pkg::FHC_CHIP_ERASE) ||
        (cur.cmd == fhc_pkg::FHC_MAIN_ERASE) || (cur.cmd == fhc_pkg::FHC_LOCKOUT);
    assign req_ready = (state == S_IDLE);

    always_comb begin
        next_state = state;
        next_cur = cur;
        next_step = step;
        next_polls = polls;
        next_have_prev = have_prev;
        next_prev_toggle = prev_toggle;
        next_rdata = rsp.rdata;
        next_timeout = rsp.timeout;
        next_rsp_valid = 1'b0;
        bus_start = 1'b0;
        bus_write = 1'b0;
        bus_addr = step_addr;
        bus_wdata = step_data;
        case (state)
            S_IDLE: begin
                if (req_valid) begin
                    next_cur = req;
                    next_step = 3'h0;
                    next_timeout = 1'b0;
                    next_state = S_ISSUE;
                end
            end
            S_ISSUE: begin
                bus_start = 1'b1;
                bus_write = (cur.cmd != fhc_pkg::FHC_READ);
                next_state = S_WAIT;
            end
            S_WAIT: begin
                if (bus_done) begin
                    if (cur.cmd == fhc_pkg::FHC_READ) begin
                        next_rdata = bus_rdata;
                        next_rsp_valid = 1'b1;
                        next_state = S_IDLE;
                    end else if (step != seq_len - 3'h1) begin
                        next_step = step + 3'h1;
                        next_state = S_ISSUE;
                    end else if (cur.cmd == fhc_pkg::FHC_PROGRAM || is_erase) begin
                        // Device times the operation itself; only watch it
                        next_polls = 32'h0;
                        next_have_prev = 1'b0;
                        next_state = S_POLL;
                    end else begin
                        next_rsp_valid = 1'b1;
                        next_state = S_IDLE;
                    end
                end
            end
            S_POLL: begin
                // Program polls the loaded word, erase any word
                bus_start = 1'b1;
                bus_addr = (cur.cmd == fhc_pkg::FHC_PROGRAM) ? cur.addr : fhc_pkg::ADDR_ANY;
                next_state = S_POLL_WAIT;
            end
            S_POLL_WAIT: begin
                if (bus_done) begin
                    next_polls = polls + 32'h1;
                    next_have_prev = 1'b1;
                    next_prev_toggle = bus_rdata[fhc_pkg::TOGGLE_BIT];
                    // Program ends when bit 7 is true again; a locked boot
                    // word may never match, so the toggle bit also ends it
                    if ((cur.cmd == fhc_pkg::FHC_PROGRAM &&
                         bus_rdata[fhc_pkg::POLL_BIT] == cur.wdata[fhc_pkg::POLL_BIT]) ||
                        (have_prev &&
                         bus_rdata[fhc_pkg::TOGGLE_BIT] == prev_toggle)) begin
                        next_rdata = bus_rdata;
                        next_rsp_valid = 1'b1;
                        next_state = S_IDLE;
                    end else if (polls == POLL_LIMIT) begin
                        next_rdata = bus_rdata;
                        next_timeout = 1'b1;
                        next_rsp_valid = 1'b1;
                        next_state = S_IDLE;
                    end else begin
                        next_state = S_POLL;
                    end
                end
            end
            default: next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state <= S_IDLE;
            cur <= '{fhc_pkg::FHC_READ, 16'h0000, 16'h0000};
            step <= 3'h0;
            polls <= 32'h0;
            have_prev <= 1'b0;
            prev_toggle <= 1'b0;
            rsp <= '{16'h0000, 1'b0};
            rsp_valid <= 1'b0;
        end else begin
            state <= next_state;
            cur <= next_cur;
            step <= next_step;
            polls <= next_polls;
            have_prev <= next_have_prev;
            prev_toggle <= next_prev_toggle;
            rsp <= '{next_rdata, next_timeout};
            rsp_valid <= next_rsp_valid;
        end
    end

    // ----------------------------------------------------------------
    // Pin timing
    // ----------------------------------------------------------------
    fhc_bus_cycle u_bus (
        .mclk(mclk),
        .rst_n(rst_n),
        .start(bus_start),
        .is_write(bus_write),
        .addr(bus_addr),
        .wdata(bus_wdata),
        .done(bus_done),
        .rdata(bus_rdata),
        .pins(pins),
        .data_lines_in(data_lines_in)
    );
endmodule

/* tb/fhc_flash_model.sv */
`timescale 1ns/1ps
module fhc_flash_model #(
    parameter logic [15:0] MFR_CODE = 16'h00C3, // Arbitrary maker code
    parameter logic [15:0] DEV_CODE = 16'h0051 // Arbitrary part code
) (
    input wire logic mclk, // Bench clock
    input wire fhc_pkg::fhc_pins_s pins, // Host pin drive
    input wire logic [11:0] busy_len, // Self-timed operation length
    output logic [15:0] data_lines_in // Resolved data lines
);
    // ------------------------------------------------------------
    // Array, command decoder and status
    // ------------------------------------------------------------
    logic [15:0] mem [0:65535];
    logic [15:0] wa, ld, last;
    logic [2:0] step;
    logic prog, id, lock, tog, act, pact, rd;
    logic [1:0] lowc;
    int busy;
    fhc_pkg::fhc_pins_s p;
    assign act = !pins.chip_sel_n && !pins.wr_strobe_n && pins.out_drive_n;
    assign pact = !p.chip_sel_n && !p.wr_strobe_n && p.out_drive_n;
    assign rd = !pins.chip_sel_n && !pins.out_drive_n && pins.wr_strobe_n;
    function automatic logic [15:0] rword(logic [15:0] a);
        if (busy > 0) return {ld[15:8], ~ld[7], tog, ld[5:0]};
        if (id && a == 16'h0000) return MFR_CODE;
        if (id && a == 16'h0001) return DEV_CODE;
        if (id && a == 16'h0002) return {15'h0000, lock};
        return mem[a];
    endfunction
    // Released lines show the inverse of the last value, never a stale copy
    always_comb begin
        if (pins.data_lines_oe) data_lines_in = pins.data_lines_out;
        else if (rd) data_lines_in = rword(pins.address_lines);
        else data_lines_in = ~last;
    end
    task do_write(input logic [15:0] a, input logic [15:0] d);
        logic h5, h2;
        h5 = a[10:0] == 11'h555;
        h2 = a[10:0] == 11'h2AA;
        step <= 3'h0;
        prog <= 1'b0;
        if (step == 3'h3 && prog) begin
            if (!(lock && a < 16'h2000)) mem[a] <= mem[a] & d;
            ld <= d;
            busy <= busy_len;
        end else if (step == 3'h0 && d[7:0] == 8'hF0) id <= 1'b0;
        else if ((step == 3'h0 || step == 3'h3) && h5 && d[7:0] == 8'hAA) step <= step + 3'h1;
        else if ((step == 3'h1 || step == 3'h4) && h2 && d[7:0] == 8'h55) step <= step + 3'h1;
        else if (step == 3'h2 && h5) begin
            step <= (d[7:0] == 8'hA0 || d[7:0] == 8'h80) ? 3'h3 : 3'h0;
            prog <= d[7:0] == 8'hA0;
            if (d[7:0] == 8'h90) id <= 1'b1;
            if (d[7:0] == 8'hF0) id <= 1'b0;
        end else if (step == 3'h5 && h5) begin
            for (int i = 0; i < 65536; i++) begin
                if (d[7:0] == 8'h10 && !(lock && i < 8192)) mem[i] <= 16'hFFFF;
                if (d[7:0] == 8'h30 && i >= 8192) mem[i] <= 16'hFFFF;
            end
            if (d[7:0] == 8'h40) lock <= 1'b1;
            ld <= 16'hFFFF;
            busy <= busy_len;
        end
    endtask
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 16'hFFFF;
        end
        {step, prog, id, lock, tog, busy, lowc, last, wa, ld} = '0;
        p = '1;
    end
    always @(posedge mclk) begin
        p <= pins;
        if (rd) last <= data_lines_in;
        if (busy > 0) busy <= busy - 1;
        if (rd && p.out_drive_n) tog <= ~tog;
        lowc <= act ? ((lowc == 2'h3) ? lowc : lowc + 2'h1) : 2'h0;
        if (act && !pact) wa <= pins.address_lines;
        // Strobes under two cycles are treated as noise
        if (pact && !act && lowc >= 2'h2 && busy == 0) begin
            do_write(wa, p.data_lines_out);
        end
    end
endmodule

/* tb/fhc_ctrl_chk.sv */
`timescale 1ns/1ps
module fhc_ctrl_chk #(
    parameter logic [31:0] POLL_LIMIT = 32'h00FFFFFF // Poll reads before timeout
) (
    input wire logic mclk, // Clock
    input wire logic rst_n, // Reset
    input wire logic req_valid, // Request offered
    input wire logic req_ready, // Request taken
    input wire fhc_pkg::fhc_req_s req, // Request
    input wire logic rsp_valid, // Completion
    input wire fhc_pkg::fhc_rsp_s rsp, // Response
    input wire fhc_pkg::fhc_pins_s pins, // Flash pins
    input wire logic [15:0] data_lines_in // Flash data
);
    // ------------------------------------------------------------
    // Pin and handshake properties
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    property p_no_fight;
        !pins.out_drive_n |-> !pins.data_lines_oe && pins.wr_strobe_n && !pins.chip_sel_n;
    endproperty
    a_no_fight: assert property (p_no_fight) else $error("host drives during read");
    property p_inhibit;
        !pins.wr_strobe_n |-> pins.out_drive_n && !pins.chip_sel_n && pins.data_lines_oe;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("strobe outside write");
    property p_pulse;
        $fell(pins.wr_strobe_n) |-> !pins.wr_strobe_n [*4] ##1 pins.wr_strobe_n;
    endproperty
    a_pulse: assert property (p_pulse) else $error("strobe width wrong");
    property p_addr_hold;
        !pins.chip_sel_n && !$past(pins.chip_sel_n) |-> $stable(pins.address_lines);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved");
    property p_data_hold;
        $rose(pins.wr_strobe_n) |-> $stable(pins.data_lines_out) && !pins.chip_sel_n;
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("data moved at strobe");
    property p_one_op;
        req_valid && req_ready |=> !req_ready [*8];
    endproperty
    a_one_op: assert property (p_one_op) else $error("ready during op");
    property p_ready_back;
        rsp_valid |-> req_ready;
    endproperty
    a_ready_back: assert property (p_ready_back) else $error("ready not back");
    property p_read_lat;
        req_valid && req_ready && req.cmd == fhc_pkg::FHC_READ |-> ##[6:14] rsp_valid;
    endproperty
    a_read_lat: assert property (p_read_lat) else $error("read too slow");
    property p_cmd_first;
        req_valid && req_ready && req.cmd != fhc_pkg::FHC_READ
            && req.cmd != fhc_pkg::FHC_ID_EXIT_SHORT |-> ##[1:12] ($fell(pins.wr_strobe_n)
            && pins.address_lines[10:0] == 11'h555 && pins.data_lines_out[7:0] == 8'hAA);
    endproperty
    a_cmd_first: assert property (p_cmd_first) else $error("bad first cycle");
    property p_rdata_stands;
        $changed(rsp.rdata) |-> rsp_valid;
    endproperty
    a_rdata_stands: assert property (p_rdata_stands) else $error("read data moved");
endmodule
bind fhc_ctrl fhc_ctrl_chk #(.POLL_LIMIT(POLL_LIMIT)) u_chk (.mclk(mclk), .rst_n(rst_n),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
    .rsp(rsp), .pins(pins), .data_lines_in(data_lines_in));

/* tb/fhc_ctrl_tb.sv */
`timescale 1ns/1ps
module fhc_ctrl_tb;
    // ------------------------------------------------------------
    // Bench, model and expectations
    // ------------------------------------------------------------
    localparam logic [15:0] ID_M = 16'h00C3; // Arbitrary maker code
    localparam logic [15:0] ID_D = 16'h0051; // Arbitrary part code
    logic mclk, rst_n, req_valid, req_ready, rsp_valid, lock;
    fhc_pkg::fhc_req_s req;
    fhc_pkg::fhc_rsp_s rsp;
    fhc_pkg::fhc_pins_s pins;
    logic [15:0] data_lines_in, got;
    logic [11:0] busy_len;
    logic [15:0] sh [int];
    int q[$];
    int bad_count, checks;
    fhc_ctrl #(.POLL_LIMIT(32'h00000010)) dut (.mclk(mclk), .rst_n(rst_n),
        .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
        .rsp(rsp), .pins(pins), .data_lines_in(data_lines_in));
    fhc_flash_model #(.MFR_CODE(ID_M), .DEV_CODE(ID_D)) flash (.mclk(mclk), .pins(pins),
        .busy_len(busy_len), .data_lines_in(data_lines_in));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    function automatic logic [15:0] expw(logic [15:0] a);
        return sh.exists(a) ? sh[a] : 16'hFFFF;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Entered just after an edge with the controller idle
    task automatic op(input fhc_pkg::fhc_cmd_e c, input logic [15:0] a, input logic [15:0] d,
        input logic to_exp);
        int n;
        req_valid <= 1'b1;
        req <= '{cmd: c, addr: a, wdata: d};
        @(posedge mclk);
        req_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (rsp_valid !== 1'b1 && n < 3000);
        if (n >= 3000) begin
            bad_count++;
            close_out();
        end
        got = rsp.rdata;
        check({15'h0000, rsp.timeout}, {15'h0000, to_exp});
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
        op(fhc_pkg::FHC_READ, a, 16'h0000, 1'b0);
        check(got, e);
    endtask
    task automatic prog(input logic [15:0] a, input logic [15:0] d);
        op(fhc_pkg::FHC_PROGRAM, a, d, 1'b0);
        if (!(lock && a < 16'h2000)) sh[a] = expw(a) & d;
        rd_chk(a, expw(a));
    endtask
    task automatic id_chk(input logic short_exit);
        op(fhc_pkg::FHC_ID_ENTRY, 16'h0555, 16'h0000, 1'b0);
        rd_chk(16'h0000, ID_M);
        rd_chk(16'h0001, ID_D);
        rd_chk(16'h0002, {15'h0000, lock});
        op(short_exit ? fhc_pkg::FHC_ID_EXIT_SHORT : fhc_pkg::FHC_ID_EXIT, 16'h0000,
            16'h0000, 1'b0);
        rd_chk(16'h0000, expw(16'h0000));
    endtask
    task automatic erase(input fhc_pkg::fhc_cmd_e c);
        op(c, 16'h0000, 16'h0000, 1'b0);
        foreach (q[i]) begin
            if (q[i] >= 8192 || (c == fhc_pkg::FHC_CHIP_ERASE && !lock)) sh[q[i]] = 16'hFFFF;
            rd_chk(16'(q[i]), expw(16'(q[i])));
        end
    endtask
    initial begin
        #600000;
        bad_count++;
        close_out();
    end
    initial begin
        int a;
        req_valid = 1'b0;
        req = '0;
        rst_n = 1'b0;
        busy_len = 12'h008;
        lock = 1'b0;
        bad_count = 0;
        checks = 0;
        void'($urandom(14));
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        check({12'h000, pins.chip_sel_n, pins.out_drive_n, pins.wr_strobe_n,
            pins.data_lines_oe}, 16'h000E);
        for (int i = 0; i < 10; i++) begin
            a = (i < 3) ? 8191 + i * 57344 / 2 : int'($urandom_range(65535));
            busy_len <= 12'(i * 9 + 2);
            prog(16'(a), 16'($urandom));
            q.push_back(a);
        end
        prog(16'(q[0]), 16'($urandom));
        $display("program test done");
        id_chk(1'b0);
        erase(fhc_pkg::FHC_MAIN_ERASE);
        $display("main erase test done");
        op(fhc_pkg::FHC_LOCKOUT, 16'h0000, 16'h0000, 1'b0);
        lock = 1'b1;
        id_chk(1'b1);
        prog(16'h1FFF, 16'h0000);
        prog(16'(q[5]), 16'h0F0F);
        erase(fhc_pkg::FHC_CHIP_ERASE);
        $display("lockout test done");
        busy_len <= 12'h7D0;
        op(fhc_pkg::FHC_PROGRAM, 16'h4000, 16'h1234, 1'b1);
        repeat (2100) @(posedge mclk);
        rd_chk(16'h4000, 16'h1234);
        $display("slow program test done");
        close_out();
    end
endmodule
